// File: hw/touch_batch_delay_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the batch delay scheduler.
// Assumes: Included by the package only; every other file reaches it through the package.
// Notes: Offsets are register indices; the byte address is four times the index.
`ifndef TOUCH_BATCH_DELAY_CONSTS_SVH
`define TOUCH_BATCH_DELAY_CONSTS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define BD_ADDR_W 8
`define BD_IDX_CFG 8'h0d
`define BD_IDX_CTL 8'h10
`define BD_IDX_STAT 8'h11
`define BD_CFG_RESET 16'h0000
`define BD_SEL_LSB 0
`define BD_SEL_MSB 2
`define BD_CTL_FUNC_MSB 3
`define BD_CTL_PSM_BIT 4
`define BD_CTL_STOP_BIT 5
`define BD_FUNC_RESET 4'hf
`define BD_FUNC_XYZ 4'h0
`define BD_FUNC_XY 4'h1
`define BD_RESP_OKAY 2'h0
`define BD_RESP_SLVERR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define BD_CLK_PERIOD_NS 50
`define BD_MS_NS 1000000
`define BD_CYC_PER_MS (`BD_MS_NS / `BD_CLK_PERIOD_NS)
`define BD_DLY_1 7'h01
`define BD_DLY_2 7'h02
`define BD_DLY_3 7'h04
`define BD_DLY_4 7'h0a
`define BD_DLY_5 7'h14
`define BD_DLY_6 7'h28
`define BD_DLY_7 7'h64

`endif

// File: hw/touch_batch_delay_pkg.sv
// Purpose: Types and shared decode functions of the batch delay scheduler.
// Assumes: The constants header sits beside this file.
// Notes: Bus carriers keep the published AXI4-Lite signal names as fields.
package touch_batch_delay_pkg;
    `include "touch_batch_delay_consts.svh"

    // Scheduler states, Gray coded along idle, run, wait.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_WAIT = 2'b11
    } sched_state_e;

    // Master to slave signals.
    typedef struct packed {
        logic awvalid;
        logic [`BD_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`BD_ADDR_W-1:0] araddr;
        logic rready;
    } axi_req_s;

    // Slave to master signals.
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

    // Delay in milliseconds for a select code; zero means no delay.
    function automatic logic [6:0] ms_of_sel(input logic [2:0] sel);
        case (sel)
            3'h1: ms_of_sel = `BD_DLY_1;
            3'h2: ms_of_sel = `BD_DLY_2;
            3'h3: ms_of_sel = `BD_DLY_3;
            3'h4: ms_of_sel = `BD_DLY_4;
            3'h5: ms_of_sel = `BD_DLY_5;
            3'h6: ms_of_sel = `BD_DLY_6;
            3'h7: ms_of_sel = `BD_DLY_7;
            default: ms_of_sel = 7'h00;
        endcase
    endfunction

    // True for the two scan codes that the scheduler paces.
    function automatic logic is_scan_code(input logic [3:0] code);
        is_scan_code = (code == `BD_FUNC_XYZ) || (code == `BD_FUNC_XY);
    endfunction
endpackage

// File: hw/batch_delay_timer.sv
// Purpose: Millisecond batch delay timer, restarted at each sample set start.
// Assumes: Start is a one-cycle strobe on I_CLK.
// Notes: A zero select leaves the timer expired, so pacing falls to processing time.
`timescale 1ns/1ps
`default_nettype none
module batch_delay_timer #(
    parameter logic [15:0] CYC_PER_MS = 16'(`BD_CYC_PER_MS) // Clock cycles per millisecond.
) (
    input wire logic I_CLK, // System clock.
    input wire logic I_RESET, // Synchronous reset, active high.
    input wire logic i_start, // Load the delay and begin counting.
    input wire logic [2:0] i_sel, // Batch delay select code.
    output logic o_expired // High from the last cycle of the delay onward.
);
    import touch_batch_delay_pkg::*;

    logic [6:0] ms_left_ff; // Whole milliseconds still to run.
    logic [15:0] pre_ff; // Cycles left in the current millisecond.
    wire pre_zero = (pre_ff == 16'h0000);

    // Expiry shows in the delay's last cycle, so a restart lands exactly on the delay boundary.
    assign o_expired = (ms_left_ff == 7'h00) || (ms_left_ff == 7'h01 && pre_zero);

    // ----------------------------------------
    // Countdown
    // ----------------------------------------
    // A restart wins over the countdown, so the delay begins at each new sample set.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ms_left_ff <= 7'h00;
            pre_ff <= 16'h0000;
        end else if (i_start) begin
            ms_left_ff <= ms_of_sel(i_sel);
            pre_ff <= CYC_PER_MS - 16'h0001;
        end else if (!o_expired) begin
            pre_ff <= pre_zero ? CYC_PER_MS - 16'h0001 : pre_ff - 16'h0001;
            ms_left_ff <= pre_zero ? ms_left_ff - 7'h01 : ms_left_ff;
        end
    end

    property p_load;
        @(posedge I_CLK) disable iff (I_RESET)
        i_start |=> (ms_left_ff == ms_of_sel($past(i_sel)));
    endproperty
    a_load: assert property (p_load) else $error("Timer did not load the selected delay.");
endmodule
`default_nettype wire

// File: hw/touch_batch_delay_scheduler.sv
// Purpose: Batch delay scheduler of a resistive touch controller, with an AXI4-Lite register slave.
// Assumes: I_SET_DONE comes from the converter sequencer on I_CLK; I_PEN_TOUCH is an outside pin.
// Notes: One write and one read may be in flight; unmapped addresses answer SLVERR.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Low three config bits select batch delay.
// - Nonzero delay paces sets by internal timer.
// - Mode bit one plus scan code: device-started.
// - Device mode: pen touch starts scan and timer.
// - Finished set waits until delay expires.
// - Expiry with pen resumes set, restarts timer.
// - Selected delay sets throughput while touched.
// - Longer processing time paces instead of delay.
// - Mode bit zero plus scan code: host-started.
// - Host scan runs while first touch lasts.
// - Codes map to 0,1,2,4,10,20,40,100 ms.
// - Repeat until pen lifts, stop, or reset.
module touch_batch_delay_scheduler
    import touch_batch_delay_pkg::*;
#(
    parameter logic [15:0] CYC_PER_MS = 16'(`BD_CYC_PER_MS) // Cycles per millisecond.
) (
    input wire logic I_CLK, // System clock, 20 MHz.
    input wire logic I_RESET, // Synchronous reset, active high.
    input wire touch_batch_delay_pkg::axi_req_s I_AXI, // AXI4-Lite master signals.
    output touch_batch_delay_pkg::axi_rsp_s O_AXI, // AXI4-Lite slave signals.
    input wire logic I_PEN_TOUCH, // Pen touch detect pin, high when touched.
    input wire logic I_SET_DONE, // Strobe: one processed sample set finished.
    output logic O_SET_START, // Strobe: begin one sample set.
    output logic O_SCAN_ACTIVE, // A paced scan is under way.
    output logic O_WAITING // Scan holds for the batch delay.
);
    import touch_batch_delay_pkg::*;

    // ----------------------------------------
    // Pen touch synchroniser
    // ----------------------------------------
    logic pen_meta_ff; // First stage, read only by the second.
    logic pen_ff; // Synchronised pen touch level.

    // Two flops keep the pin's metastability away from the scheduler.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            pen_meta_ff <= 1'b0;
            pen_ff <= 1'b0;
        end else begin
            pen_meta_ff <= I_PEN_TOUCH;
            pen_ff <= pen_meta_ff;
        end
    end

    // ----------------------------------------
    // Register write channel
    // ----------------------------------------
    logic aw_held_ff; // Write address captured.
    logic [`BD_ADDR_W-1:0] aw_addr_ff; // Captured write address.
    logic w_held_ff; // Write data captured.
    logic [31:0] w_data_ff; // Captured write data.
    logic [3:0] w_strb_ff; // Captured byte enables.
    logic bvalid_ff; // Write response pending.
    logic [1:0] bresp_ff; // Write response code.

    // Address and data are taken independently and joined before the write.
    wire aw_ready = !aw_held_ff && !bvalid_ff;
    wire w_ready = !w_held_ff && !bvalid_ff;
    wire aw_take = I_AXI.awvalid && aw_ready;
    wire w_take = I_AXI.wvalid && w_ready;
    wire do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    wire [7:0] w_idx = {2'b00, aw_addr_ff[7:2]};
    wire w_lane0 = w_strb_ff[0];
    wire cfg_wr = do_write && (w_idx == `BD_IDX_CFG) && w_lane0;
    wire ctl_wr = do_write && (w_idx == `BD_IDX_CTL) && w_lane0;
    wire w_mapped = (w_idx == `BD_IDX_CFG) || (w_idx == `BD_IDX_CTL);
    wire stop_req = ctl_wr && w_data_ff[`BD_CTL_STOP_BIT];

    // Holding registers and the write response.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `BD_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= I_AXI.awaddr;
            end else if (do_write) begin
                aw_held_ff <= 1'b0;
            end
            if (w_take) begin
                w_held_ff <= 1'b1;
                w_data_ff <= I_AXI.wdata;
                w_strb_ff <= I_AXI.wstrb;
            end else if (do_write) begin
                w_held_ff <= 1'b0;
            end
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= w_mapped ? `BD_RESP_OKAY : `BD_RESP_SLVERR;
            end else if (I_AXI.bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Configuration and control registers
    // ----------------------------------------
    logic [15:0] cfg_ff; // Batch delay configuration, reserved bits held zero.
    logic [3:0] func_ff; // Converter function field.
    logic psm_ff; // Pen scan mode select.
    logic engage_ff; // Host has engaged a scan not yet started.

    wire [2:0] batch_delay_select = cfg_ff[`BD_SEL_MSB:`BD_SEL_LSB];
    wire scan_code = is_scan_code(func_ff);
    wire dev_mode = psm_ff && scan_code;
    wire host_mode = !psm_ff && scan_code;
    // A write that carries the stop bit never engages, or the scan would restart at once.
    wire host_engage = ctl_wr && !stop_req && !w_data_ff[`BD_CTL_PSM_BIT] && is_scan_code(w_data_ff[3:0]);

    // Only the select bits are stored; the rest of the word stays zero.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            cfg_ff <= `BD_CFG_RESET;
            func_ff <= `BD_FUNC_RESET;
            psm_ff <= 1'b0;
        end else begin
            if (cfg_wr) begin
                cfg_ff <= {13'h0000, w_data_ff[`BD_SEL_MSB:`BD_SEL_LSB]};
            end
            if (ctl_wr) begin
                func_ff <= w_data_ff[`BD_CTL_FUNC_MSB:0];
                psm_ff <= w_data_ff[`BD_CTL_PSM_BIT];
            end
        end
    end

    // ----------------------------------------
    // Scheduler
    // ----------------------------------------
    sched_state_e state_ff; // Scheduler state.
    sched_state_e nxt_state; // Next scheduler state.
    logic nxt_set_start; // Begin a sample set this cycle.
    logic set_start_ff; // Registered start strobe.
    logic timer_expired; // Batch delay has run out.

    wire abort = stop_req || !pen_ff || !scan_code;
    wire dev_go = dev_mode && pen_ff;
    wire host_go = host_mode && engage_ff && pen_ff;

    // Engage request is kept until the scan starts or a stop; a new write wins.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            engage_ff <= 1'b0;
        end else begin
            engage_ff <= host_engage || (engage_ff && !nxt_set_start && !stop_req);
        end
    end

    // The next set needs both the delay gone and the previous set finished.
    always_comb begin
        nxt_state = state_ff;
        nxt_set_start = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (!stop_req && (dev_go || host_go)) begin
                    nxt_set_start = 1'b1;
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (abort) begin
                    nxt_state = ST_IDLE;
                end else if (I_SET_DONE && timer_expired) begin
                    nxt_set_start = 1'b1;
                end else if (I_SET_DONE) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (abort) begin
                    nxt_state = ST_IDLE;
                end else if (timer_expired) begin
                    nxt_set_start = 1'b1;
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // State and the start strobe register together.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state_ff <= ST_IDLE;
            set_start_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            set_start_ff <= nxt_set_start;
        end
    end

    // The timer restarts with every set, so throughput follows the select.
    batch_delay_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .I_CLK(I_CLK),
        .I_RESET(I_RESET),
        .i_start(nxt_set_start),
        .i_sel(batch_delay_select),
        .o_expired(timer_expired)
    );

    assign O_SET_START = set_start_ff;
    assign O_SCAN_ACTIVE = (state_ff != ST_IDLE);
    assign O_WAITING = (state_ff == ST_WAIT);

    // ----------------------------------------
    // Register read channel
    // ----------------------------------------
    logic rvalid_ff; // Read data pending.
    logic [31:0] rdata_ff; // Read data.
    logic [1:0] rresp_ff; // Read response code.
    wire [7:0] r_idx = {2'b00, I_AXI.araddr[7:2]};
    wire ar_take = I_AXI.arvalid && !rvalid_ff;
    wire [31:0] stat_word = {26'h0, engage_ff, timer_expired, pen_ff, 1'b0, state_ff};
    wire [31:0] ctl_word = {27'h0, psm_ff, func_ff};
    wire r_cfg = (r_idx == `BD_IDX_CFG);
    wire r_ctl = (r_idx == `BD_IDX_CTL);
    wire r_stat = (r_idx == `BD_IDX_STAT);
    wire [31:0] r_word = r_cfg ? {16'h0000, cfg_ff} : r_ctl ? ctl_word : r_stat ? stat_word : 32'h0;
    wire r_mapped = r_cfg || r_ctl || r_stat;

    // Data is latched when the address is taken and held until rready.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `BD_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= r_word;
            rresp_ff <= r_mapped ? `BD_RESP_OKAY : `BD_RESP_SLVERR;
        end else if (I_AXI.rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign O_AXI.awready = aw_ready;
    assign O_AXI.wready = w_ready;
    assign O_AXI.bvalid = bvalid_ff;
    assign O_AXI.bresp = bresp_ff;
    assign O_AXI.arready = !rvalid_ff;
    assign O_AXI.rvalid = rvalid_ff;
    assign O_AXI.rdata = rdata_ff;
    assign O_AXI.rresp = rresp_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_reserved_zero;
        @(posedge I_CLK) disable iff (I_RESET)
        cfg_ff[15:3] == 13'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved config bits not zero.");

    property p_dev_start;
        @(posedge I_CLK) disable iff (I_RESET)
        (state_ff == ST_IDLE && dev_mode && pen_ff && !stop_req) |=> (O_SET_START && state_ff == ST_RUN);
    endproperty
    a_dev_start: assert property (p_dev_start) else $error("Pen touch did not start a scan.");

    property p_host_hold;
        @(posedge I_CLK) disable iff (I_RESET)
        (state_ff == ST_IDLE && !psm_ff && !engage_ff) |=> !O_SET_START;
    endproperty
    a_host_hold: assert property (p_host_hold) else $error("Host mode started without engage.");

    property p_wait_entry;
        @(posedge I_CLK) disable iff (I_RESET)
        (state_ff == ST_RUN && I_SET_DONE && !timer_expired && !abort) |=> (state_ff == ST_WAIT && !O_SET_START);
    endproperty
    a_wait_entry: assert property (p_wait_entry) else $error("Set finished early did not wait.");

    property p_resume;
        @(posedge I_CLK) disable iff (I_RESET)
        (state_ff == ST_WAIT && timer_expired && !abort) |=> (O_SET_START && state_ff == ST_RUN);
    endproperty
    a_resume: assert property (p_resume) else $error("Expired delay did not resume.");

    property p_restart;
        @(posedge I_CLK) disable iff (I_RESET)
        (nxt_set_start && batch_delay_select != 3'h0) |=> !timer_expired;
    endproperty
    a_restart: assert property (p_restart) else $error("Delay timer not restarted.");

    property p_accrual;
        @(posedge I_CLK) disable iff (I_RESET)
        (state_ff == ST_RUN && I_SET_DONE && timer_expired && !abort) |=> O_SET_START;
    endproperty
    a_accrual: assert property (p_accrual) else $error("Late set not followed at once.");

    property p_pen_lift;
        @(posedge I_CLK) disable iff (I_RESET)
        (state_ff != ST_IDLE && !pen_ff) |=> (state_ff == ST_IDLE && !O_SET_START);
    endproperty
    a_pen_lift: assert property (p_pen_lift) else $error("Scan went on after pen lift.");

    property p_stop;
        @(posedge I_CLK) disable iff (I_RESET)
        stop_req |=> (state_ff == ST_IDLE) ##1 (state_ff == ST_IDLE || pen_ff);
    endproperty
    a_stop: assert property (p_stop) else $error("Stop did not end the scan.");

    property p_start_pen;
        @(posedge I_CLK) disable iff (I_RESET)
        O_SET_START |-> $past(pen_ff);
    endproperty
    a_start_pen: assert property (p_start_pen) else $error("Set started without pen touch.");
endmodule
`default_nettype wire

// File: verification/conv_seq_model.sv
// Purpose: Converter sequencer stand-in that answers a set start with a done strobe unless a newer start comes first.
// Assumes: Start is a one-cycle strobe; the latency input is steady while a set runs.
// Notes: Latency is in clock cycles; a large value models slow processing of a set.
`timescale 1ns/1ps
`default_nettype none
module conv_seq_model (
    input wire logic i_clk, // Bench clock.
    input wire logic i_rst, // Synchronous reset, active high.
    input wire logic i_start, // Set start strobe from the scheduler.
    input wire logic [7:0] i_lat, // Processing time in cycles.
    output logic o_done // One-cycle strobe: set finished.
);
    logic seen = 1'b0; // Start seen in the half cycle before the edge.
    logic busy; // A set is being processed.
    logic [7:0] cnt; // Cycles of processing left.

    // Sample on the falling edge, so the rising-edge update never races the scheduler.
    always @(negedge i_clk) seen = i_start;

    // Count the processing time down, then pulse done once.
    always @(posedge i_clk) begin
        o_done <= !i_rst && !seen && busy && (cnt == 8'h00);
        if (i_rst) begin
            busy <= 1'b0;
        end else if (seen) begin
            busy <= 1'b1;
            cnt <= i_lat;
        end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
        end else if (busy) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: verification/touch_batch_delay_scheduler_tb_top.sv
// Purpose: Self-checking bench of the batch delay scheduler and its register slave.
// Assumes: A short millisecond keeps the longest delay code within a few thousand cycles.
// Notes: Outputs are judged on the falling edge, where the last rising edge has settled.
`timescale 1ns/1ps
`default_nettype none
module touch_batch_delay_scheduler_tb_top;
    import touch_batch_delay_pkg::*;
    localparam logic [15:0] CPM = 16'h0008; // Cycles per millisecond in simulation.
    localparam int MS [8] = '{0, 1, 2, 4, 10, 20, 40, 100}; // Delay of each select code.
    localparam logic [7:0] A_CFG = 8'h34; // Delay configuration byte address.
    localparam logic [7:0] A_CTL = 8'h40; // Control byte address.
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pen = 1'b0;
    logic done;
    logic [7:0] lat = 8'h02;
    axi_req_s req = '0;
    axi_rsp_s rsp;
    logic set_start;
    logic scan_act;
    logic waiting;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int last_t = 0;
    int n_start = 0;
    bit first = 1'b1; // Next start only marks time, it has no gap before it.
    int sq[$]; // Expected gaps between set starts.
    logic [33:0] rq[$]; // Expected read response and data.
    logic [1:0] bq[$]; // Expected write responses.

    always #25 clk = ~clk;

    touch_batch_delay_scheduler #(.CYC_PER_MS(CPM)) dut (.I_CLK(clk), .I_RESET(rst), .I_AXI(req), .O_AXI(rsp),
        .I_PEN_TOUCH(pen), .I_SET_DONE(done), .O_SET_START(set_start), .O_SCAN_ACTIVE(scan_act), .O_WAITING(waiting));
    conv_seq_model seq (.i_clk(clk), .i_rst(rst), .i_start(set_start), .i_lat(lat), .o_done(done));

    task automatic chk(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // -------------------------------------------
    // Monitor: takes the oldest note per result
    // -------------------------------------------
    always @(negedge clk) begin
        cyc++;
        if (set_start === 1'b1) begin
            n_start++;
            if (!first && sq.size() != 0) begin
                chk(cyc - last_t == sq[0], "set start spacing");
                sq.delete(0);
            end
            first = 1'b0;
            last_t = cyc;
        end
        if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
            chk(bq.size() != 0 && rsp.bresp === bq[0], "write response");
            if (bq.size() != 0) bq.delete(0);
        end
        if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
            chk(rq.size() != 0 && {rsp.rresp, rsp.rdata} === rq[0], "read data");
            if (rq.size() != 0) rq.delete(0);
        end
    end

    // Write one word; each half is dropped at the edge that takes it, bready held until bvalid.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ta;
        bit tw;
        bit tb;
        int n = 0;
        bq.push_back(er);
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = req.awvalid && rsp.awready;
            tw = req.wvalid && rsp.wready;
            tb = rsp.bvalid && req.bready;
            @(posedge clk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            n++;
        end while (!tb && n < 100);
        req.bready <= 1'b0;
        chk(tb, "write timeout");
    endtask

    // Read one word; rready stays high until rvalid is seen.
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        bit ta;
        bit tr;
        int n = 0;
        rq.push_back(e);
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = req.arvalid && rsp.arready;
            tr = rsp.rvalid && req.rready;
            @(posedge clk);
            if (ta) req.arvalid <= 1'b0;
            n++;
        end while (!tr && n < 100);
        req.rready <= 1'b0;
        chk(tr, "read timeout");
    endtask

    // One touch runs three paced sets; the gap is the delay or, if longer, the processing time.
    task automatic paced(input logic [2:0] sel, input logic pen_scan_mode_select, input int l);
        int d;
        int k;
        logic [3:0] code;
        code = 4'($urandom_range(0, 1));
        d = MS[sel] * CPM;
        if (d < l + 3) d = l + 3; // Slow processing dominates: start, model latency, done.
        lat <= 8'(l);
        wr(A_CFG, ({$urandom} & 32'hfffffff8) | 32'(sel), 2'h0);
        rd(A_CFG, {2'h0, 29'h0, sel});
        wr(A_CTL, {27'h0, pen_scan_mode_select, pen_scan_mode_select ? code : 4'hf}, 2'h0);
        first = 1'b1;
        k = n_start;
        @(posedge clk);
        pen <= 1'b1;
        if (!pen_scan_mode_select) begin
            repeat (8) @(negedge clk);
            chk(n_start == k, "start without host");
            wr(A_CTL, {27'h0, 1'b0, code}, 2'h0);
        end
        repeat (3) sq.push_back(d);
        for (int n = 0; n < 4000 && sq.size() != 0; n++) @(negedge clk);
        chk(sq.size() == 0, "sets not paced");
        if (MS[sel] * CPM > l + 10) begin
            repeat (l + 7) @(negedge clk);
            chk(waiting === 1'b1, "no hold for delay");
        end
        @(posedge clk);
        pen <= 1'b0;
        for (int n = 0; n < 20 && scan_act !== 1'b0; n++) @(negedge clk);
        chk(scan_act === 1'b0, "scan outlived touch");
        if (!pen_scan_mode_select) begin
            k = n_start;
            @(posedge clk);
            pen <= 1'b1;
            repeat (12) @(negedge clk);
            chk(n_start == k, "host scan resumed unasked");
            @(posedge clk);
            pen <= 1'b0;
        end
        repeat (4) @(posedge clk);
    endtask

    // -------------------------------------------
    // Main sequence and watchdog
    // -------------------------------------------
    initial begin
        void'($urandom(86396));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(A_CFG, 34'h0);
        rd(A_CTL, {2'h0, 32'h0000000f});
        rd(8'h08, {2'h2, 32'h0});
        wr(8'h44, 32'h0, 2'h2);
        for (int s = 0; s < 8; s++) paced(3'(s), 1'b1, $urandom_range(0, 2));
        paced(3'h1, 1'b1, 20);
        paced(3'h3, 1'b0, 1);
        paced(3'h0, 1'b0, 2);
        wr(A_CTL, 32'h0, 2'h0);
        @(posedge clk);
        pen <= 1'b1;
        repeat (12) @(negedge clk);
        chk(scan_act === 1'b1, "host scan not engaged");
        wr(A_CTL, 32'h20, 2'h0);
        repeat (6) @(negedge clk);
        chk(scan_act === 1'b0, "stop did not end scan");
        @(posedge clk);
        pen <= 1'b0;
        wr(A_CTL, 32'h10, 2'h0);
        @(posedge clk);
        pen <= 1'b1;
        repeat (30) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        pen <= 1'b0;
        @(negedge clk);
        chk(scan_act === 1'b0, "scan survived reset");
        rd(A_CFG, 34'h0);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
